// ---- verilog/drill_params.svh ----
// timing, offsets and reset values of the drill controller
`ifndef DRILL_PARAMS_SVH
`define DRILL_PARAMS_SVH
`define CLK_HZ        25000000
`define OSC_HZ        5529600
`define PWM_HZ        100
`define RETRY_MS      10
`define SLOPE_S       32
`define DAMAGE_S      60
`define WAKE_MS       1000
`define RAMP_MS       4
`define BLINK_MS      250
`define INIT_MS       1
`define OFS_DUTY      8'h00
`define OFS_THR_LO    8'h04
`define OFS_THR_HI    8'h08
`define OFS_STATUS    8'h0C
`define DUTY_RST      32'h00FF_A050
`define MV_PER_LSB    5
`define LOW_MV        13800
`define OFF_MV        12000
`define FULL_MV       19800
`define DMG_MV        20400
`define CHG_MV        16000
`define ST_FAULT_BIT  9
`define ST_DMG_BIT    10
`define ST_FULL_BIT   11
`define ST_LOW_BIT    12
`define ST_DUTY_LSB   16
`endif

// ---- verilog/drill_pkg.sv ----
// types shared by the drill controller
package drill_pkg;
    typedef struct packed {
        logic [7:0] rsv;
        logic [7:0] high;
        logic [7:0] med;
        logic [7:0] low;
    } duty_cfg_t;
    typedef struct packed {
        logic [3:0]  rsv1;
        logic [11:0] b;
        logic [3:0]  rsv0;
        logic [11:0] a;
    } thr_t;
    typedef enum logic [8:0] {
        S_INIT   = 9'h001,
        S_IDLE   = 9'h002,
        S_RUN    = 9'h004,
        S_FAULT  = 9'h008,
        S_CHARGE = 9'h010,
        S_DMG    = 9'h020,
        S_HALT   = 9'h040,
        S_SHUT   = 9'h080,
        S_SPARE  = 9'h100
    } state_t;
endpackage : drill_pkg

// ---- verilog/drill_motor_charger_control.sv ----
// drill motor pwm and battery charger controller with apb registers
`timescale 1ns/1ps
`include "drill_params.svh"
// What this block does
// - motor pwm at fixed 100Hz
// - all intervals derived from system clock
// - sample battery slope every 32 s
// - negative slope drives charger output low
// - motor and charger never together
// - three duty levels from speed switch
// - separate battery and motor leds
// - overcurrent comparator stops pwm at once
// - retry pwm every 10 ms
// - blink motor led on failed retry
// - reset initialises all timers and ports
// - measure battery, update flags after init
// - out of limits: damage flag, 60 s charge
// - trigger with charge runs selected speed
// - track speed switch and trigger while running
// - pwm off on release or empty battery
// - idle motor: charge if charger, not full
// - no charger or full: off, halt
// - leave halt on wake timeout or trigger
// - low battery led at or below 13.8V
// - shut down at 12V
// - ramp duty up to selected level
module drill_motor_charger_control #(
    parameter int MS_CYC  = `CLK_HZ / 1000,
    parameter int PWM_CYC = `CLK_HZ / `PWM_HZ
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        trigger_input,
    input  wire logic [1:0]  speed_sel,
    input  wire logic        current_sense_input,
    input  wire logic [11:0] batt_code,
    input  wire logic [11:0] chg_code,
    output logic             motor_pwm_out,
    output logic             charger_out,
    output logic             battery_led_out,
    output logic             motor_led_out,
    output logic             low_battery_led
);
    localparam int PW = $clog2(PWM_CYC + 1);
    localparam int MW = $clog2(MS_CYC + 1);
    localparam logic [PW-1:0] STEP = PW'(PWM_CYC / 256);
    localparam logic [15:0] T_RETRY = 16'(`RETRY_MS);
    localparam logic [15:0] T_SLOPE = 16'(`SLOPE_S * 1000);
    localparam logic [15:0] T_DMG   = 16'(`DAMAGE_S * 1000);
    localparam logic [15:0] T_WAKE  = 16'(`WAKE_MS);
    localparam logic [15:0] T_INIT  = 16'(`INIT_MS);
    localparam logic [2:0]  T_RAMP  = 3'(`RAMP_MS);
    localparam logic [7:0]  T_BLINK = 8'(`BLINK_MS);
    localparam logic [11:0] C_LOW  = 12'(`LOW_MV / `MV_PER_LSB);
    localparam logic [11:0] C_OFF  = 12'(`OFF_MV / `MV_PER_LSB);
    localparam logic [11:0] C_FULL = 12'(`FULL_MV / `MV_PER_LSB);
    localparam logic [11:0] C_DMG  = 12'(`DMG_MV / `MV_PER_LSB);
    localparam logic [11:0] C_CHG  = 12'(`CHG_MV / `MV_PER_LSB);

    if (PWM_CYC < 256 || MS_CYC < 2 || PWM_CYC >= 2**24) begin : g_bad
        $error("pwm or ms period out of range");
    end

    // synchroniser: trigger, speed[1:0], comparator
    logic [3:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;
    logic [MW-1:0] ms_r, ms_nxt;
    logic       tick;

    always_comb begin
        filt_nxt = filt_r;
        // a change counts only once stages 2 and 3 agree
        for (int i = 0; i < 4; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                filt_nxt[i] = s3_r[i];
            end
        end
        tick   = (ms_r == MW'(MS_CYC - 1));
        ms_nxt = tick ? '0 : ms_r + MW'(1);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r   <= 4'h0;
            s2_r   <= 4'h0;
            s3_r   <= 4'h0;
            filt_r <= 4'h0;
            ms_r   <= '0;
        end else begin
            s1_r   <= {current_sense_input, speed_sel, trigger_input};
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            filt_r <= filt_nxt;
            ms_r   <= ms_nxt;
        end
    end

    logic       trig, oc;
    logic [1:0] spd;
    assign trig = filt_r[0];
    assign spd  = filt_r[2:1];
    assign oc   = filt_r[3];

    // apb slave: zero wait states, read data caught in setup
    drill_pkg::duty_cfg_t duty_cfg_r, duty_cfg_nxt;
    drill_pkg::thr_t      thr_lo_r, thr_lo_nxt;
    drill_pkg::thr_t      thr_hi_r, thr_hi_nxt;
    logic [31:0] rd_r, rd_nxt, status;
    logic        err_r, err_nxt;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == `OFS_DUTY) || (a == `OFS_THR_LO) ||
                 (a == `OFS_THR_HI) || (a == `OFS_STATUS);
    endfunction : mapped

    assign pready  = psel & penable;
    assign prdata  = rd_r;
    assign pslverr = err_r & psel & penable;

    always_comb begin
        duty_cfg_nxt = duty_cfg_r;
        thr_lo_nxt   = thr_lo_r;
        thr_hi_nxt   = thr_hi_r;
        rd_nxt       = rd_r;
        err_nxt      = err_r;
        if (psel && !penable) begin
            err_nxt = !mapped(paddr) || (pwrite && paddr == `OFS_STATUS);
            case (paddr)
                `OFS_DUTY:   rd_nxt = {8'h00, duty_cfg_r[23:0]};
                `OFS_THR_LO: rd_nxt = thr_lo_r;
                `OFS_THR_HI: rd_nxt = thr_hi_r;
                `OFS_STATUS: rd_nxt = status;
                default:     rd_nxt = 32'h0000_0000;
            endcase
        end
        if (psel && penable && pwrite && !err_r) begin
            case (paddr)
                `OFS_DUTY:   duty_cfg_nxt = {8'h00, pwdata[23:0]};
                `OFS_THR_LO: thr_lo_nxt = pwdata & 32'h0FFF_0FFF;
                `OFS_THR_HI: thr_hi_nxt = pwdata & 32'h0FFF_0FFF;
                default:     ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_cfg_r <= `DUTY_RST;
            thr_lo_r   <= {4'h0, C_OFF, 4'h0, C_LOW};
            thr_hi_r   <= {4'h0, C_DMG, 4'h0, C_FULL};
            rd_r       <= 32'h0000_0000;
            err_r      <= 1'b0;
        end else begin
            duty_cfg_r <= duty_cfg_nxt;
            thr_lo_r   <= thr_lo_nxt;
            thr_hi_r   <= thr_hi_nxt;
            rd_r       <= rd_nxt;
            err_r      <= err_nxt;
        end
    end

    function automatic logic [7:0] duty_for(input logic [1:0] s,
                                            input drill_pkg::duty_cfg_t c);
        case (s)
            2'h2:    duty_for = c.med;
            2'h3:    duty_for = c.high;
            default: duty_for = c.low;
        endcase
    endfunction : duty_for

    // control state machine and timers
    drill_pkg::state_t st_r, st_nxt;
    logic [15:0]   tmr_r, tmr_nxt;
    logic [PW-1:0] pc_r, pc_nxt;
    logic [7:0]    duty_r, duty_nxt, target;
    logic [2:0]    ramp_r, ramp_nxt;
    logic [7:0]    bc_r, bc_nxt;
    logic          blink_r, blink_nxt;
    logic [11:0]   vprev_r, vprev_nxt;
    logic          fault_r, fault_nxt, dmg_r, dmg_nxt;
    logic          full_r, full_nxt, trip_r, trip_nxt;
    logic          pwm_nxt, chg_nxt, bled_nxt, mled_nxt, low_nxt;
    logic          chg_ok, full_now, empty, out_lim, wrap, run_n;

    assign target   = duty_for(spd, duty_cfg_r);
    assign chg_ok   = chg_code >= C_CHG;
    assign empty    = batt_code <= thr_lo_r.b;
    assign full_now = full_r || batt_code >= thr_hi_r.a;
    assign out_lim  = batt_code < thr_lo_r.b || batt_code > thr_hi_r.b;
    assign wrap     = (pc_r == PW'(PWM_CYC - 1));
    assign status   = {3'h0, 1'b0, 4'h0, duty_r, 3'h0, low_battery_led,
                       full_r, dmg_r, fault_r, st_r};

    always_comb begin
        st_nxt    = st_r;
        tmr_nxt   = tick ? tmr_r + 16'h0001 : tmr_r;
        duty_nxt  = duty_r;
        ramp_nxt  = ramp_r;
        vprev_nxt = vprev_r;
        fault_nxt = fault_r;
        dmg_nxt   = dmg_r;
        full_nxt  = full_r;
        trip_nxt  = trip_r;
        // full flag rearms once the pack has run low again
        if (batt_code <= thr_lo_r.a) begin
            full_nxt = 1'b0;
        end
        case (st_r)
            drill_pkg::S_INIT: begin
                if (tmr_r == T_INIT) begin
                    if (out_lim) begin
                        dmg_nxt = 1'b1;
                        st_nxt  = drill_pkg::S_DMG;
                    end else begin
                        st_nxt = drill_pkg::S_IDLE;
                    end
                end
            end
            drill_pkg::S_IDLE: begin
                if (!out_lim) begin
                    dmg_nxt = 1'b0;
                end
                if (empty) begin
                    st_nxt = drill_pkg::S_SHUT;
                end else if (trig) begin
                    duty_nxt = 8'h00;
                    ramp_nxt = 3'h0;
                    trip_nxt = 1'b0;
                    st_nxt   = drill_pkg::S_RUN;
                end else if (chg_ok && !full_now) begin
                    vprev_nxt = batt_code;
                    st_nxt    = drill_pkg::S_CHARGE;
                end else begin
                    st_nxt = drill_pkg::S_HALT;
                end
            end
            drill_pkg::S_RUN: begin
                if (!trig || empty) begin
                    st_nxt = drill_pkg::S_IDLE;
                end else if (oc) begin
                    fault_nxt = 1'b1;
                    trip_nxt  = 1'b1;
                    st_nxt    = drill_pkg::S_FAULT;
                end else begin
                    // speed drop follows at once, rises are ramped
                    if (duty_r > target) begin
                        duty_nxt = target;
                    end else if (tick && duty_r < target) begin
                        ramp_nxt = ramp_r + 3'h1;
                        if (ramp_r == T_RAMP - 3'h1) begin
                            ramp_nxt = 3'h0;
                            duty_nxt = duty_r + 8'h01;
                        end
                    end
                    // after a retry, the second whole clean period clears the fault indication
                    if (wrap) begin
                        if (!trip_r) begin
                            fault_nxt = 1'b0;
                        end
                        trip_nxt = 1'b0;
                    end
                end
            end
            drill_pkg::S_FAULT: begin
                if (!trig) begin
                    st_nxt = drill_pkg::S_IDLE;
                end else if (tmr_r == T_RETRY) begin
                    duty_nxt = target;
                    st_nxt   = drill_pkg::S_RUN;
                end
            end
            drill_pkg::S_CHARGE: begin
                if (trig) begin
                    st_nxt = drill_pkg::S_IDLE;
                end else if (!chg_ok || full_now) begin
                    st_nxt = drill_pkg::S_HALT;
                end else if (tmr_r == T_SLOPE) begin
                    tmr_nxt   = 16'h0000;
                    vprev_nxt = batt_code;
                    if (batt_code < vprev_r) begin
                        full_nxt = 1'b1;
                        st_nxt   = drill_pkg::S_HALT;
                    end
                end
            end
            drill_pkg::S_DMG: begin
                if (tmr_r == T_DMG) begin
                    st_nxt = drill_pkg::S_IDLE;
                end
            end
            drill_pkg::S_HALT: begin
                if (trig || tmr_r == T_WAKE) begin
                    st_nxt = drill_pkg::S_IDLE;
                end
            end
            drill_pkg::S_SHUT: begin
                if (chg_ok && !full_now) begin
                    vprev_nxt = batt_code;
                    st_nxt    = drill_pkg::S_CHARGE;
                end
            end
            default: st_nxt = drill_pkg::S_INIT;
        endcase
        if (st_nxt != st_r) begin
            tmr_nxt = 16'h0000;
        end
        run_n  = (st_nxt == drill_pkg::S_RUN);
        pc_nxt = (!run_n || st_r != drill_pkg::S_RUN || wrap) ? '0 : pc_r + PW'(1);
    end

    // led blink and registered pin outputs
    always_comb begin
        bc_nxt    = tick ? bc_r + 8'h01 : bc_r;
        blink_nxt = blink_r;
        if (tick && bc_r == T_BLINK - 8'h01) begin
            bc_nxt    = 8'h00;
            blink_nxt = !blink_r;
        end
        // comparator gates the edge directly, no wait for the fsm
        pwm_nxt  = run_n && !oc && (pc_nxt < PW'(duty_nxt) * STEP);
        chg_nxt  = (st_nxt == drill_pkg::S_CHARGE ||
                    st_nxt == drill_pkg::S_DMG) && !run_n;
        bled_nxt = dmg_nxt ? blink_r : chg_nxt;
        mled_nxt = fault_nxt ? blink_r : run_n;
        low_nxt  = batt_code <= thr_lo_r.a;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r            <= drill_pkg::S_INIT;
            tmr_r           <= 16'h0000;
            pc_r            <= '0;
            duty_r          <= 8'h00;
            ramp_r          <= 3'h0;
            bc_r            <= 8'h00;
            blink_r         <= 1'b0;
            vprev_r         <= 12'h000;
            fault_r         <= 1'b0;
            dmg_r           <= 1'b0;
            full_r          <= 1'b0;
            trip_r          <= 1'b0;
            motor_pwm_out   <= 1'b0;
            charger_out     <= 1'b0;
            battery_led_out <= 1'b0;
            motor_led_out   <= 1'b0;
            low_battery_led <= 1'b0;
        end else begin
            st_r            <= st_nxt;
            tmr_r           <= tmr_nxt;
            pc_r            <= pc_nxt;
            duty_r          <= duty_nxt;
            ramp_r          <= ramp_nxt;
            bc_r            <= bc_nxt;
            blink_r         <= blink_nxt;
            vprev_r         <= vprev_nxt;
            fault_r         <= fault_nxt;
            dmg_r           <= dmg_nxt;
            full_r          <= full_nxt;
            trip_r          <= trip_nxt;
            motor_pwm_out   <= pwm_nxt;
            charger_out     <= chg_nxt;
            battery_led_out <= bled_nxt;
            motor_led_out   <= mled_nxt;
            low_battery_led <= low_nxt;
        end
    end
endmodule : drill_motor_charger_control

// ---- verification/drill_plant.sv ----
// far-side model: motor switch shunt, battery and charger adapter sensing
`timescale 1ns/1ps
module drill_plant (
    input  wire logic        pclk,
    input  wire logic        motor_pwm_out,
    input  wire logic        overload,
    input  wire logic        plug,
    input  wire logic [11:0] batt_set,
    output logic             current_sense_input,
    output logic      [11:0] batt_code,
    output logic      [11:0] chg_code
);
    logic sense_r = 1'b0;
    // shunt carries current only while the switch conducts, one cycle late
    always @(posedge pclk) begin
        sense_r <= motor_pwm_out & overload;
    end
    assign current_sense_input = sense_r;
    assign batt_code           = batt_set;
    // unplugged adapter divider is pulled to ground
    assign chg_code            = plug ? 12'hD48 : 12'h000;
endmodule : drill_plant

// ---- verification/drill_ctrl_sva.sv ----
// concurrent checks on the drill controller ports
`timescale 1ns/1ps
module drill_ctrl_sva #(
    parameter int MS_CYC  = 25000,
    parameter int PWM_CYC = 250000
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        trigger_input,
    input wire logic        current_sense_input,
    input wire logic [11:0] batt_code,
    input wire logic        motor_pwm_out,
    input wire logic        charger_out,
    input wire logic        low_battery_led
);
    localparam int PW_MAX = PWM_CYC - 1;
    // counter instead of a delay range: a real period is far beyond any range limit
    int hi_cnt_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_cnt_r <= 0;
        end else begin
            hi_cnt_r <= motor_pwm_out ? hi_cnt_r + 1 : 0;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_excl; !(motor_pwm_out && charger_out); endproperty
    a_excl: assert property (p_excl) else $error("motor and charger on together");
    property p_trip; $rose(current_sense_input) |-> ##[1:7] !motor_pwm_out; endproperty
    a_trip: assert property (p_trip) else $error("pwm not stopped on overcurrent");
    property p_hold; $rose(current_sense_input) |-> ##7 (!motor_pwm_out)[*8]; endproperty
    a_hold: assert property (p_hold) else $error("pwm back too soon after trip");
    property p_release; (!trigger_input)[*7] |-> !motor_pwm_out; endproperty
    a_release: assert property (p_release) else $error("pwm on with trigger released");
    property p_low_on; (batt_code <= 12'hAC8)[*3] |-> low_battery_led; endproperty
    a_low_on: assert property (p_low_on) else $error("low battery led off");
    property p_low_off; (batt_code > 12'hAC8)[*3] |-> !low_battery_led; endproperty
    a_low_off: assert property (p_low_off) else $error("low battery led on");
    property p_width; hi_cnt_r <= PW_MAX; endproperty
    a_width: assert property (p_width) else $error("pwm high beyond one period");
    property p_ready; pready == (psel && penable); endproperty
    a_ready: assert property (p_ready) else $error("pready outside access phase");
    property p_err; pslverr |-> psel && penable; endproperty
    a_err: assert property (p_err) else $error("pslverr outside access phase");
    c_trip: cover property ($rose(current_sense_input));
    c_chg: cover property ($rose(charger_out));
    c_low: cover property ($rose(low_battery_led));
endmodule : drill_ctrl_sva
bind drill_motor_charger_control drill_ctrl_sva #(.MS_CYC(MS_CYC), .PWM_CYC(PWM_CYC)) chk (
    .pclk, .presetn, .psel, .penable, .pready, .pslverr, .trigger_input, .current_sense_input,
    .batt_code, .motor_pwm_out, .charger_out, .low_battery_led);

// ---- verification/tb_top.sv ----
// self-checking bench for the drill controller
`timescale 1ns/1ps
module tb_top;
    localparam int MS = 8;
    localparam int PW = 512;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic        pready, pslverr, rerr, led0;
    logic        trigger_input = 1'b0, overload = 1'b0, plug = 1'b0, current_sense_input;
    logic [1:0]  speed_sel = 2'b00;
    logic [11:0] batt_set = 12'hBB8, batt_code, chg_code;
    logic        motor_pwm_out, charger_out, battery_led_out, motor_led_out, low_battery_led;
    int          fail_count = 0, checks = 0, n, hi, per;
    logic [1:0]  spd[3] = '{2'b10, 2'b00, 2'b01};
    logic [7:0]  lvl[3] = '{8'h80, 8'h40, 8'h40};
    always #20 pclk = ~pclk;
    drill_motor_charger_control #(.MS_CYC(MS), .PWM_CYC(PW)) uut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .trigger_input, .speed_sel, .current_sense_input,
        .batt_code, .chg_code, .motor_pwm_out, .charger_out, .battery_led_out, .motor_led_out, .low_battery_led);
    drill_plant plant (.pclk, .motor_pwm_out, .overload, .plug, .batt_set, .current_sense_input, .batt_code,
        .chg_code);
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: flag %b want %b", $time, got, exp);
        end
    endtask : chk_bit
    // called just after a rising edge; leaves one idle cycle behind
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // no wait-state count assumed; only the watchdog ends this wait
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wait_st(input logic [8:0] s, input int polls);
        for (int i = 0; i < polls; i++) begin
            apb(1'b0, 8'h0C, 32'h0);
            if (rdat[8:0] === s) break;
        end
        chk_word({23'h0, rdat[8:0]}, {23'h0, s});
    endtask : wait_st
    // waits for the next pwm rising edge, counting cycles
    task automatic rise();
        n = 0;
        while (motor_pwm_out === 1'b1 && n < 2000) begin n++; @(posedge pclk); end
        while (motor_pwm_out !== 1'b1 && n < 2000) begin n++; @(posedge pclk); end
    endtask : rise
    task automatic measure();
        rise();
        hi = 0;
        per = 0;
        while (motor_pwm_out === 1'b1 && per < 2000) begin hi++; per++; @(posedge pclk); end
        while (motor_pwm_out !== 1'b1 && per < 2000) begin per++; @(posedge pclk); end
    endtask : measure
    task automatic final_report();
        $display("mismatches %0d checks %0d", fail_count, checks);
        if (fail_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    initial begin
        #(40 * 80000);
        fail_count++;
        final_report();
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_word({27'h0, motor_pwm_out, charger_out, battery_led_out, motor_led_out, low_battery_led}, 32'h0);
        apb(1'b0, 8'h00, 32'h0); chk_word(rdat, 32'h00FF_A050);
        apb(1'b0, 8'h04, 32'h0); chk_word(rdat, 32'h0960_0AC8);
        apb(1'b0, 8'h08, 32'h0); chk_word(rdat, 32'h0FF0_0F78);
        apb(1'b0, 8'h10, 32'h0); chk_word({rdat[31:1], rerr}, 32'h0000_0001);
        apb(1'b1, 8'h0C, 32'hFFFF_FFFF); chk_bit(rerr, 1'b1);
        apb(1'b1, 8'h00, 32'hFFC0_8040);
        apb(1'b0, 8'h00, 32'h0); chk_word(rdat, 32'h00C0_8040);
        wait_st(9'h040, 600);
        speed_sel <= 2'b11;
        trigger_input <= 1'b1;
        wait_st(9'h004, 30);
        repeat (40 * MS) @(posedge pclk);
        apb(1'b0, 8'h0C, 32'h0); chk_bit(rdat[23:16] > 8'h00 && rdat[23:16] < 8'hC0, 1'b1);
        for (int i = 0; i < 3000 && rdat[23:16] !== 8'hC0; i++) apb(1'b0, 8'h0C, 32'h0);
        measure(); chk_word(hi, 32'd384);
        chk_word(per, PW);
        chk_bit(motor_led_out, 1'b1);
        // lower speeds take effect without a ramp
        for (int i = 0; i < 3; i++) begin
            speed_sel <= spd[i];
            measure();
            measure(); chk_word(hi, {23'h0, lvl[i], 1'b0});
        end
        rise();
        overload <= 1'b1;
        repeat (12) @(posedge pclk);
        chk_bit(motor_pwm_out, 1'b0);
        apb(1'b0, 8'h0C, 32'h0); chk_word(rdat & 32'h0000_03FF, 32'h0000_0208);
        rise(); chk_bit(n >= 60 && n <= 610, 1'b1);
        led0 = motor_led_out;
        n = 0;
        while (motor_led_out === led0 && n < 2100) begin n++; @(posedge pclk); end
        chk_bit(n < 2100, 1'b1);
        overload <= 1'b0;
        for (int i = 0; i < 600; i++) begin
            apb(1'b0, 8'h0C, 32'h0);
            if (rdat[9] === 1'b0) break;
        end
        chk_bit(rdat[9], 1'b0);
        trigger_input <= 1'b0;
        repeat (10) @(posedge pclk);
        chk_bit(motor_pwm_out, 1'b0);
        wait_st(9'h040, 30);
        plug <= 1'b1;
        wait_st(9'h010, 4000);
        chk_word({30'h0, charger_out, battery_led_out}, 32'h3);
        trigger_input <= 1'b1;
        wait_st(9'h004, 30); chk_bit(charger_out, 1'b0);
        trigger_input <= 1'b0;
        plug <= 1'b0;
        batt_set <= 12'hAC8;
        repeat (4) @(posedge pclk);
        chk_bit(low_battery_led, 1'b1);
        batt_set <= 12'hAC9;
        repeat (4) @(posedge pclk);
        chk_bit(low_battery_led, 1'b0);
        batt_set <= 12'h960;
        trigger_input <= 1'b1;
        wait_st(9'h080, 40); chk_bit(motor_pwm_out, 1'b0);
        trigger_input <= 1'b0;
        presetn <= 1'b0;
        batt_set <= 12'hFFA;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_word({27'h0, motor_pwm_out, charger_out, battery_led_out, motor_led_out, low_battery_led}, 32'h0);
        wait_st(9'h020, 600); chk_bit(rdat[10], 1'b1);
        chk_bit(charger_out, 1'b1);
        final_report();
    end
endmodule : tb_top
